// ==== hdl/sync_serial_port.sv ====
/*
  Synchronous serial port pin logic with a transmit FIFO.
  Assumes all pin inputs are asynchronous to clk and that the link's
  bit clock is well below half the rate of clk.
*/
`timescale 1ns/1ps
`include "sync_serial_port_params.svh"

// ******************************************************************
// Transmit FIFO.
// ******************************************************************
module sync_serial_fifo #(
  parameter int WIDTH = `SSP_WORD_BITS,
  parameter int DEPTH = `SSP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] wr_d;
  logic [AW:0] rd_q;
  logic [AW:0] rd_d;

  function automatic logic [AW:0] ptr_inc(input logic [AW:0] p);
    ptr_inc = p + {{AW{1'b0}}, 1'b1};
  endfunction : ptr_inc

  assign out_valid = (wr_q != rd_q);
  assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_data = mem_q[rd_q[AW-1:0]];

  always_comb
  begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (in_valid && in_ready)
    begin
      mem_d[wr_q[AW-1:0]] = in_data;
      wr_d = ptr_inc(wr_q);
    end
    if (out_valid && out_ready)
    begin
      rd_d = ptr_inc(rd_q);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= '0;
      end
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end
endmodule : sync_serial_fifo

// ******************************************************************
// Port top level.
// ******************************************************************
module sync_serial_port (
  input wire logic clk,
  input wire logic nrst,
  input sync_serial_port_pkg::cfg_t cfg,
  input wire logic [`SSP_WORD_BITS-1:0] tx_wdata,
  input wire logic tx_wvalid,
  output logic tx_wready,
  input wire logic [`SSP_WORD_BITS-1:0] tx1_word,
  output logic [`SSP_WORD_BITS-1:0] rx_word,
  output logic rx_valid,
  output logic flag0_in,
  input wire logic [`SSP_NPINS-1:0] gpio_o,
  input wire logic [`SSP_NPINS-1:0] gpio_oe,
  output logic [`SSP_NPINS-1:0] gpio_i,
  input wire logic port0_tx_data_i,
  output logic port0_tx_data_o,
  output logic port0_tx_data_oe,
  input wire logic port0_rx_data_i,
  output logic port0_rx_data_o,
  output logic port0_rx_data_oe,
  input wire logic port0_bit_clock_i,
  output logic port0_bit_clock_o,
  output logic port0_bit_clock_oe,
  input wire logic port0_ctrl_pin0_i,
  output logic port0_ctrl_pin0_o,
  output logic port0_ctrl_pin0_oe,
  input wire logic port0_ctrl_pin1_i,
  output logic port0_ctrl_pin1_o,
  output logic port0_ctrl_pin1_oe,
  input wire logic port0_ctrl_pin2_i,
  output logic port0_ctrl_pin2_o,
  output logic port0_ctrl_pin2_oe
);
  localparam logic [`SSP_DIV_BITS-1:0] HALF_M1 = `SSP_DIV_BITS'(`SSP_BCLK_HALF_CYC - 1);

  // ****************************************************************
  // Pin synchronisers, clock generation and edge detection.
  // ****************************************************************
  logic [`SSP_NPINS-1:0] pins_in;
  logic [`SSP_NPINS-1:0] sync1_q;
  logic [`SSP_NPINS-1:0] sync2_q;
  logic [`SSP_DIV_BITS-1:0] div_q;
  logic [`SSP_DIV_BITS-1:0] div_d;
  logic gen_q;
  logic gen_d;
  logic bclk_q;
  logic bclk_d;
  logic rclk_q;
  logic rclk_d;
  logic tx_re;
  logic tx_fe;
  logic rx_fe;

  assign pins_in = {port0_ctrl_pin2_i, port0_ctrl_pin1_i, port0_ctrl_pin0_i,
                    port0_bit_clock_i, port0_rx_data_i, port0_tx_data_i};
  assign gpio_i = sync2_q;
  assign flag0_in = sync2_q[`SSP_PIN_C0];

  always_comb
  begin
    div_d = div_q;
    gen_d = gen_q;
    if (cfg.enable && (cfg.clk_out || cfg.rxclk_out))
    begin
      if (div_q == HALF_M1)
      begin
        div_d = '0;
        gen_d = !gen_q;
      end
      else
      begin
        div_d = div_q + `SSP_DIV_BITS'(1);
      end
    end
    else
    begin
      div_d = '0;
      gen_d = 1'b0;
    end
    // Edges are found only when the clock moves, so a gated clock is fine.
    bclk_d = cfg.clk_out ? gen_q : sync2_q[`SSP_PIN_CLK];
    if (cfg.sync_mode)
    begin
      rclk_d = bclk_d;
    end
    else
    begin
      rclk_d = cfg.rxclk_out ? gen_q : sync2_q[`SSP_PIN_C0];
    end
  end

  assign tx_re = bclk_d && !bclk_q;
  assign tx_fe = !bclk_d && bclk_q;
  assign rx_fe = !rclk_d && rclk_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_q <= `SSP_PINS_RST;
      sync2_q <= `SSP_PINS_RST;
      div_q <= '0;
      gen_q <= 1'b0;
      bclk_q <= 1'b0;
      rclk_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      div_q <= div_d;
      gen_q <= gen_d;
      bclk_q <= bclk_d;
      rclk_q <= rclk_d;
    end
  end

  // ****************************************************************
  // Transmitter.
  // ****************************************************************
  sync_serial_port_pkg::tx_state_t tx_state_q;
  sync_serial_port_pkg::tx_state_t tx_state_d;
  logic [`SSP_WORD_BITS-1:0] tx_sh_q;
  logic [`SSP_WORD_BITS-1:0] tx_sh_d;
  logic [`SSP_WORD_BITS-1:0] tx1_sh_q;
  logic [`SSP_WORD_BITS-1:0] tx1_sh_d;
  logic [`SSP_CNT_BITS-1:0] tx_cnt_q;
  logic [`SSP_CNT_BITS-1:0] tx_cnt_d;
  logic fs_gen_q;
  logic fs_gen_d;
  logic pend_q;
  logic pend_d;
  logic fs_src;
  logic [`SSP_WORD_BITS-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  sync_serial_fifo #(
    .WIDTH(`SSP_WORD_BITS),
    .DEPTH(`SSP_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_data(tx_wdata),
    .in_valid(tx_wvalid),
    .in_ready(tx_wready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  assign fs_src = cfg.fs_out ? fs_gen_q : sync2_q[`SSP_PIN_C2];
  assign fifo_pop = cfg.enable && tx_re && pend_q;

  always_comb
  begin
    tx_state_d = tx_state_q;
    tx_sh_d = tx_sh_q;
    tx1_sh_d = tx1_sh_q;
    tx_cnt_d = tx_cnt_q;
    fs_gen_d = fs_gen_q;
    pend_d = pend_q;
    if (!cfg.enable)
    begin
      tx_state_d = sync_serial_port_pkg::TX_IDLE;
      tx_sh_d = `SSP_WORD_RST;
      tx1_sh_d = `SSP_WORD_RST;
      tx_cnt_d = `SSP_CNT_ZERO;
      fs_gen_d = 1'b0;
      pend_d = 1'b0;
    end
    else if (tx_fe)
    begin
      pend_d = fs_src;
    end
    else if (tx_re)
    begin
      pend_d = 1'b0;
      case (tx_state_q)
        sync_serial_port_pkg::TX_IDLE:
          fs_gen_d = fifo_valid && !pend_q;
        sync_serial_port_pkg::TX_SHIFT:
          fs_gen_d = fifo_valid && (tx_cnt_q == `SSP_ARM_BIT);
        default:
          fs_gen_d = 1'b0;
      endcase
      if (pend_q)
      begin
        tx_state_d = sync_serial_port_pkg::TX_SHIFT;
        tx_sh_d = fifo_valid ? fifo_data : `SSP_WORD_RST;
        tx1_sh_d = tx1_word;
        tx_cnt_d = `SSP_CNT_ZERO;
      end
      else if (tx_state_q == sync_serial_port_pkg::TX_SHIFT)
      begin
        tx_sh_d = {tx_sh_q[`SSP_WORD_BITS-2:0], 1'b0};
        tx1_sh_d = {tx1_sh_q[`SSP_WORD_BITS-2:0], 1'b0};
        tx_cnt_d = tx_cnt_q + `SSP_CNT_ONE;
        if (tx_cnt_q == `SSP_LAST_BIT)
        begin
          tx_state_d = sync_serial_port_pkg::TX_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_state_q <= sync_serial_port_pkg::TX_IDLE;
      tx_sh_q <= `SSP_WORD_RST;
      tx1_sh_q <= `SSP_WORD_RST;
      tx_cnt_q <= `SSP_CNT_ZERO;
      fs_gen_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      tx_state_q <= tx_state_d;
      tx_sh_q <= tx_sh_d;
      tx1_sh_q <= tx1_sh_d;
      tx_cnt_q <= tx_cnt_d;
      fs_gen_q <= fs_gen_d;
      pend_q <= pend_d;
    end
  end

  // ****************************************************************
  // Receiver.
  // ****************************************************************
  logic rx_act_q;
  logic rx_act_d;
  logic [`SSP_CNT_BITS-1:0] rx_cnt_q;
  logic [`SSP_CNT_BITS-1:0] rx_cnt_d;
  logic [`SSP_WORD_BITS-1:0] rx_sh_q;
  logic [`SSP_WORD_BITS-1:0] rx_sh_d;
  logic [`SSP_WORD_BITS-1:0] rx_word_q;
  logic [`SSP_WORD_BITS-1:0] rx_word_d;
  logic rx_valid_q;
  logic rx_valid_d;
  logic rx_start;
  logic rx_last;

  // Asynchronous mode has no receive frame sync pin, so words run back to back.
  assign rx_start = cfg.sync_mode ? fs_src : 1'b1;
  assign rx_last = (rx_cnt_q == `SSP_LAST_BIT);

  always_comb
  begin
    rx_act_d = rx_act_q;
    rx_cnt_d = rx_cnt_q;
    rx_sh_d = rx_sh_q;
    rx_word_d = rx_word_q;
    rx_valid_d = 1'b0;
    if (!cfg.enable)
    begin
      rx_act_d = 1'b0;
      rx_cnt_d = `SSP_CNT_ZERO;
    end
    else if (rx_fe)
    begin
      if (rx_act_q)
      begin
        rx_sh_d = {rx_sh_q[`SSP_WORD_BITS-2:0], sync2_q[`SSP_PIN_RX]};
        rx_cnt_d = rx_cnt_q + `SSP_CNT_ONE;
        if (rx_last)
        begin
          rx_word_d = {rx_sh_q[`SSP_WORD_BITS-2:0], sync2_q[`SSP_PIN_RX]};
          rx_valid_d = 1'b1;
        end
      end
      rx_act_d = (rx_act_q && !rx_last) || rx_start;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= `SSP_CNT_ZERO;
      rx_sh_q <= `SSP_WORD_RST;
      rx_word_q <= `SSP_WORD_RST;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_act_q <= rx_act_d;
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q <= rx_sh_d;
      rx_word_q <= rx_word_d;
      rx_valid_q <= rx_valid_d;
    end
  end

  assign rx_word = rx_word_q;
  assign rx_valid = rx_valid_q;

  // ****************************************************************
  // Pin drivers.
  // ****************************************************************
  logic [`SSP_NPINS-1:0] port_o;
  logic [`SSP_NPINS-1:0] port_oe;
  logic [`SSP_NPINS-1:0] pin_o;
  logic [`SSP_NPINS-1:0] pin_oe;

  always_comb
  begin
    port_o = `SSP_PINS_RST;
    port_oe = `SSP_PINS_RST;
    port_o[`SSP_PIN_TX] = tx_sh_q[`SSP_WORD_BITS-1];
    port_oe[`SSP_PIN_TX] = 1'b1;
    port_o[`SSP_PIN_CLK] = gen_q;
    port_oe[`SSP_PIN_CLK] = cfg.clk_out;
    if (!cfg.sync_mode)
    begin
      port_o[`SSP_PIN_C0] = gen_q;
      port_oe[`SSP_PIN_C0] = cfg.rxclk_out;
    end
    else if (cfg.ctrl0_tx1)
    begin
      port_o[`SSP_PIN_C0] = tx1_sh_q[`SSP_WORD_BITS-1];
      port_oe[`SSP_PIN_C0] = 1'b1;
    end
    else
    begin
      port_o[`SSP_PIN_C0] = cfg.flag0_val;
      port_oe[`SSP_PIN_C0] = cfg.flag0_drive;
    end
    port_o[`SSP_PIN_C1] = gpio_o[`SSP_PIN_C1];
    port_oe[`SSP_PIN_C1] = gpio_oe[`SSP_PIN_C1];
    port_o[`SSP_PIN_C2] = fs_gen_q;
    port_oe[`SSP_PIN_C2] = cfg.fs_out;
    pin_o = cfg.enable ? port_o : gpio_o;
    pin_oe = cfg.enable ? port_oe : gpio_oe;
  end

  assign port0_tx_data_o = pin_o[`SSP_PIN_TX];
  assign port0_tx_data_oe = pin_oe[`SSP_PIN_TX];
  assign port0_rx_data_o = pin_o[`SSP_PIN_RX];
  assign port0_rx_data_oe = pin_oe[`SSP_PIN_RX];
  assign port0_bit_clock_o = pin_o[`SSP_PIN_CLK];
  assign port0_bit_clock_oe = pin_oe[`SSP_PIN_CLK];
  assign port0_ctrl_pin0_o = pin_o[`SSP_PIN_C0];
  assign port0_ctrl_pin0_oe = pin_oe[`SSP_PIN_C0];
  assign port0_ctrl_pin1_o = pin_o[`SSP_PIN_C1];
  assign port0_ctrl_pin1_oe = pin_oe[`SSP_PIN_C1];
  assign port0_ctrl_pin2_o = pin_o[`SSP_PIN_C2];
  assign port0_ctrl_pin2_oe = pin_oe[`SSP_PIN_C2];
endmodule : sync_serial_port

// ==== hdl/sync_serial_port_params.svh ====
/*
  Constants for the synchronous serial port: pin indices, word size,
  buffer depth, bit clock timing and reset values.
  Assumes a 100 MHz system clock.
*/
`ifndef SYNC_SERIAL_PORT_PARAMS_SVH
`define SYNC_SERIAL_PORT_PARAMS_SVH

`define SSP_PIN_TX 0
`define SSP_PIN_RX 1
`define SSP_PIN_CLK 2
`define SSP_PIN_C0 3
`define SSP_PIN_C1 4
`define SSP_PIN_C2 5
`define SSP_NPINS 6
`define SSP_WORD_BITS 16
`define SSP_FIFO_DEPTH 16
`define SSP_CNT_BITS 4
`define SSP_LAST_BIT 4'hF
`define SSP_ARM_BIT 4'hE
`define SSP_CNT_ZERO 4'h0
`define SSP_CNT_ONE 4'h1
`define SSP_CLK_PERIOD_NS 10
`define SSP_BCLK_PERIOD_NS 160
`define SSP_BCLK_HALF_CYC ((`SSP_BCLK_PERIOD_NS / 2) / `SSP_CLK_PERIOD_NS)
`define SSP_DIV_BITS 8
`define SSP_WORD_RST 16'h0000
`define SSP_PINS_RST 6'h00

`endif

// ==== hdl/sync_serial_port_pkg.sv ====
/*
  Types shared by the synchronous serial port.
  Assumes the constants header is on the include path.
*/
package sync_serial_port_pkg;

  // ****************************************************************
  // Configuration carried as one bundle.
  // ****************************************************************
  typedef struct packed {
    logic enable;
    logic sync_mode;
    logic clk_out;
    logic fs_out;
    logic rxclk_out;
    logic ctrl0_tx1;
    logic flag0_drive;
    logic flag0_val;
  } cfg_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;

endpackage : sync_serial_port_pkg

// ==== tb/sync_serial_port_assertions.sv ====
/*
  Pin checker for the serial port.
  Assumes cfg only changes while nrst is low.
*/
`timescale 1ns/1ps
// ********
// Checker.
// ********
module sync_serial_port_assertions (
  input wire logic clk,
  input wire logic nrst,
  input sync_serial_port_pkg::cfg_t cfg,
  input wire logic rx_valid,
  input wire logic [5:0] gpio_o,
  input wire logic [5:0] gpio_oe,
  input wire logic port0_tx_data_oe,
  input wire logic port0_rx_data_oe,
  input wire logic port0_bit_clock_o,
  input wire logic port0_bit_clock_oe,
  input wire logic port0_ctrl_pin0_o,
  input wire logic port0_ctrl_pin0_oe,
  input wire logic port0_ctrl_pin1_oe,
  input wire logic port0_ctrl_pin2_o,
  input wire logic port0_ctrl_pin2_oe
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_clk_high;
    port0_bit_clock_o[*8] ##1 !port0_bit_clock_o;
  endsequence
  sequence s_fs_bit;
    port0_ctrl_pin2_o[*8] ##1 port0_ctrl_pin2_o[*8] ##1 !port0_ctrl_pin2_o;
  endsequence
  property p_gpio_mode;
    !cfg.enable |-> {port0_ctrl_pin2_o, port0_ctrl_pin2_oe, port0_bit_clock_oe,
      port0_tx_data_oe} == {gpio_o[5], gpio_oe[5], gpio_oe[2], gpio_oe[0]};
  endproperty
  a_gpio_mode: assert property (p_gpio_mode)
    else $error("pins not under gpio control");
  property p_ctrl1;
    port0_ctrl_pin1_oe == gpio_oe[4];
  endproperty
  a_ctrl1: assert property (p_ctrl1)
    else $error("control pin 1 not gpio");
  property p_data_dir;
    cfg.enable |-> port0_tx_data_oe && !port0_rx_data_oe;
  endproperty
  a_data_dir: assert property (p_data_dir)
    else $error("data pin direction wrong");
  property p_clk_dir;
    cfg.enable |-> port0_bit_clock_oe == cfg.clk_out;
  endproperty
  a_clk_dir: assert property (p_clk_dir)
    else $error("bit clock direction wrong");
  property p_clk_half;
    cfg.enable && cfg.clk_out && $rose(port0_bit_clock_o) |-> s_clk_high;
  endproperty
  a_clk_half: assert property (p_clk_half)
    else $error("bit clock high time wrong");
  property p_fs_dir;
    cfg.enable |-> port0_ctrl_pin2_oe == cfg.fs_out;
  endproperty
  a_fs_dir: assert property (p_fs_dir)
    else $error("frame sync direction wrong");
  property p_fs_bit;
    cfg.enable && cfg.fs_out && $rose(port0_ctrl_pin2_o) |-> s_fs_bit;
  endproperty
  a_fs_bit: assert property (p_fs_bit)
    else $error("frame sync width wrong");
  property p_ctrl0_sync;
    cfg.enable && cfg.sync_mode |-> port0_ctrl_pin0_oe == (cfg.ctrl0_tx1 || cfg.flag0_drive);
  endproperty
  a_ctrl0_sync: assert property (p_ctrl0_sync)
    else $error("control pin 0 role wrong");
  property p_flag0;
    cfg.enable && cfg.sync_mode && !cfg.ctrl0_tx1 && cfg.flag0_drive
      |-> port0_ctrl_pin0_o == cfg.flag0_val;
  endproperty
  a_flag0: assert property (p_flag0)
    else $error("flag 0 level wrong");
  property p_ctrl0_async;
    cfg.enable && !cfg.sync_mode |-> port0_ctrl_pin0_oe == cfg.rxclk_out;
  endproperty
  a_ctrl0_async: assert property (p_ctrl0_async)
    else $error("receive clock direction wrong");
  property p_rx_pulse;
    rx_valid |=> (!rx_valid)[*8];
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("receive strobe too long");
endmodule : sync_serial_port_assertions

bind sync_serial_port sync_serial_port_assertions chk (
  .clk(clk),
  .nrst(nrst),
  .cfg(cfg),
  .rx_valid(rx_valid),
  .gpio_o(gpio_o),
  .gpio_oe(gpio_oe),
  .port0_tx_data_oe(port0_tx_data_oe),
  .port0_rx_data_oe(port0_rx_data_oe),
  .port0_bit_clock_o(port0_bit_clock_o),
  .port0_bit_clock_oe(port0_bit_clock_oe),
  .port0_ctrl_pin0_o(port0_ctrl_pin0_o),
  .port0_ctrl_pin0_oe(port0_ctrl_pin0_oe),
  .port0_ctrl_pin1_oe(port0_ctrl_pin1_oe),
  .port0_ctrl_pin2_o(port0_ctrl_pin2_o),
  .port0_ctrl_pin2_oe(port0_ctrl_pin2_oe)
);

// ==== tb/sync_serial_codec_model.sv ====
/*
  Codec at the far end of the link.
  Assumes the bench resolves each pin from both drivers.
*/
`timescale 1ns/1ps
module sync_serial_codec_model (
  input wire logic bclk_i,
  input wire logic fs_i,
  input wire logic sd_i,
  input wire logic sd1_i,
  input wire logic [15:0] word_i,
  output logic bclk_o,
  output logic fs_o,
  output logic sd_o,
  output logic [15:0] got,
  output logic [15:0] got1,
  output int got_cnt
);
  logic [15:0] sh;
  logic [15:0] sh1;
  logic [15:0] out_w;
  int cnt = 0;
  initial
  begin
    bclk_o = 1'b0;
    fs_o = 1'b0;
    sd_o = 1'b0;
    got_cnt = 0;
  end
  // Runs one frame as clock master; the clock stands still afterwards.
  task automatic frame();
    #3;
    for (int b = 0; b < 17; b++)
    begin
      bclk_o = 1'b1;
      fs_o = (b == 0);
      #80;
      bclk_o = 1'b0;
      #80;
    end
  endtask : frame
  always @(negedge bclk_i)
  begin
    if (cnt > 0)
    begin
      sh = {sh[14:0], sd_i};
      sh1 = {sh1[14:0], sd1_i};
      cnt = cnt - 1;
      if (cnt == 0)
      begin
        got = sh;
        got1 = sh1;
        got_cnt++;
      end
    end
    if (fs_i)
    begin
      cnt = 16;
      out_w = word_i;
    end
  end
  // Outside a frame the data line toggles so no stale bit is read.
  always @(posedge bclk_i)
    sd_o = (cnt > 0) ? out_w[cnt-1] : ~sd_o;
endmodule : sync_serial_codec_model

// ==== tb/sync_serial_port_tb.sv ====
/*
  Self-checking bench for the serial port.
  Assumes the codec model and the checker are compiled first.
*/
`timescale 1ns/1ps
module sync_serial_port_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  sync_serial_port_pkg::cfg_t cfg = 8'h00;
  logic [15:0] tx_wdata = 16'h0000;
  logic tx_wvalid = 1'b0;
  logic tx_wready;
  logic [15:0] tx1_word = 16'h0000;
  logic [15:0] rx_word;
  logic rx_valid;
  logic flag0_in;
  logic [5:0] gpio_o = 6'h00;
  logic [5:0] gpio_oe = 6'h00;
  logic [5:0] gpio_i;
  logic [5:0] ext = 6'h00;
  logic [5:0] po;
  logic [5:0] poe;
  logic [5:0] pin;
  logic bclk_p;
  logic fs_p;
  logic sd_p;
  logic [15:0] word_p = 16'h0000;
  logic [15:0] got;
  logic [15:0] got1;
  logic a;
  int got_cnt;
  int n;
  int error_cnt = 0;
  int comparisons = 0;
  int rx_pulses = 0;
  int seed = 32'hE9BF26EA;
  logic [15:0] q[$];
  always #5 clk = ~clk;
  // Counts receive strobes away from the edge that launches them.
  always @(negedge clk)
    if (rx_valid === 1'b1)
      rx_pulses++;
  assign pin = (poe & po) |
    (~poe & (cfg.enable ? {fs_p, ext[4:3], bclk_p, sd_p, ext[0]} : ext));
  sync_serial_port dut (
    .clk(clk),
    .nrst(nrst),
    .cfg(cfg),
    .tx_wdata(tx_wdata),
    .tx_wvalid(tx_wvalid),
    .tx_wready(tx_wready),
    .tx1_word(tx1_word),
    .rx_word(rx_word),
    .rx_valid(rx_valid),
    .flag0_in(flag0_in),
    .gpio_o(gpio_o),
    .gpio_oe(gpio_oe),
    .gpio_i(gpio_i),
    .port0_tx_data_i(pin[0]), .port0_tx_data_o(po[0]), .port0_tx_data_oe(poe[0]),
    .port0_rx_data_i(pin[1]), .port0_rx_data_o(po[1]), .port0_rx_data_oe(poe[1]),
    .port0_bit_clock_i(pin[2]), .port0_bit_clock_o(po[2]), .port0_bit_clock_oe(poe[2]),
    .port0_ctrl_pin0_i(pin[3]), .port0_ctrl_pin0_o(po[3]), .port0_ctrl_pin0_oe(poe[3]),
    .port0_ctrl_pin1_i(pin[4]), .port0_ctrl_pin1_o(po[4]), .port0_ctrl_pin1_oe(poe[4]),
    .port0_ctrl_pin2_i(pin[5]), .port0_ctrl_pin2_o(po[5]), .port0_ctrl_pin2_oe(poe[5])
  );
  sync_serial_codec_model codec (
    .bclk_i(pin[2]),
    .fs_i(pin[5]),
    .sd_i(pin[0]),
    .sd1_i(pin[3]),
    .word_i(word_p),
    .bclk_o(bclk_p),
    .fs_o(fs_p),
    .sd_o(sd_p),
    .got(got),
    .got1(got1),
    .got_cnt(got_cnt)
  );
  function automatic logic [15:0] pin_exp(input logic [5:0] o, input logic [5:0] oe,
                                          input logic [5:0] e);
    return {10'h000, (oe & o) | (~oe & e)};
  endfunction : pin_exp
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic restart(input logic [7:0] c);
    @(posedge clk);
    nrst <= 1'b0;
    cfg <= c;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask : restart
  // Leaves the valid strobe high; the caller lowers it.
  task automatic push(input logic [15:0] w);
    q.push_back(w);
    tx_wdata <= w;
    tx_wvalid <= 1'b1;
    @(negedge clk);
    for (int k = 0; k < 5000 && tx_wready !== 1'b1; k++)
      @(negedge clk);
    @(posedge clk);
  endtask : push
  task automatic frame_chk(input logic [15:0] exp, input logic sync);
    int m;
    @(posedge clk);
    tx1_word <= 16'($random(seed));
    word_p <= 16'($random(seed));
    @(posedge clk);
    m = rx_pulses;
    codec.frame();
    check("tx word", exp, got);
    if (sync)
    begin
      check("tx1 word", tx1_word, got1);
      check("rx word", word_p, rx_word);
      check("rx_valid pulses", 16'(m + 1), 16'(rx_pulses));
    end
  endtask : frame_chk
  initial
  begin
    #400000;
    error_cnt++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      gpio_o <= 6'($random(seed));
      gpio_oe <= 6'($random(seed));
      ext <= 6'($random(seed));
      repeat (4) @(negedge clk);
      check("gpio_i", pin_exp(gpio_o, gpio_oe, ext), {10'h000, gpio_i});
    end
    $display("test gpio done");
    restart(8'hC4);
    for (int i = 0; i < 16; i++)
      push(16'($random(seed)));
    fork
      push(16'($random(seed)));
    join_none
    repeat (4) @(negedge clk);
    check("tx_wready", 16'h0000, {15'h0000, tx_wready});
    frame_chk(q.pop_front(), 1'b1);
    @(posedge clk);
    tx_wvalid <= 1'b0;
    for (int i = 0; i < 16; i++)
      frame_chk(q.pop_front(), 1'b1);
    frame_chk(16'h0000, 1'b0);
    $display("test external clock done");
    restart({7'h79, 1'($random(seed))});
    word_p <= 16'($random(seed));
    for (int i = 0; i < 3; i++)
      push(16'($random(seed)));
    tx_wvalid <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      n = got_cnt;
      for (int k = 0; k < 600 && got_cnt == n; k++)
        @(negedge clk);
      check("master word", q.pop_front(), got);
    end
    repeat (20) @(negedge clk);
    check("rx word", word_p, rx_word);
    check("flag 0", {14'h0000, {2{cfg.flag0_val}}}, {14'h0000, flag0_in, gpio_i[3]});
    $display("test device clock done");
    restart(8'h88);
    push(16'($random(seed)));
    tx_wvalid <= 1'b0;
    frame_chk(q.pop_front(), 1'b0);
    @(negedge clk);
    a = gpio_i[3];
    repeat (8) @(negedge clk);
    check("rx clock", {15'h0000, ~a}, {15'h0000, gpio_i[3]});
    $display("test async done");
    restart(8'hC0);
    ext <= 6'($random(seed));
    repeat (4) @(negedge clk);
    check("flag 0 input", {15'h0000, ext[3]}, {15'h0000, flag0_in});
    $display("test flag input done");
    conclude();
  end
endmodule : sync_serial_port_tb
